// *** shared/event_reporter_pkg.sv ***
// Package for the analog channel event reporter: register map, field
// positions, reset values, event and error codes, state encodings.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package event_reporter_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DIAG_EN = 8'h04;
    localparam logic [7:0] OFF_HW_STATUS = 8'h08;
    localparam logic [7:0] OFF_HW_ACK = 8'h0C;
    localparam logic [7:0] OFF_DIAG_STATUS = 8'h10;
    localparam logic [7:0] OFF_DIAG_ACK = 8'h14;
    localparam logic [7:0] OFF_VALUE_STATUS = 8'h18;
    localparam logic [7:0] OFF_START_INFO = 8'h1C;
    // Control fields
    localparam int CTRL_VS_MODE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DIAG_EN_RESET = 32'h0000_0000;
    // Additional information layout
    localparam logic [15:0] USER_STRUCTURE_ID = 16'h0001;
    localparam int INFO_CHAN_LSB = 8;
    localparam int INFO_EVENT_LSB = 0;
    localparam int INFO_USI_LSB = 16;
    // Hardware interrupt event codes
    localparam logic [7:0] EV_LOW1 = 8'h03;
    localparam logic [7:0] EV_HIGH1 = 8'h04;
    localparam logic [7:0] EV_LOW2 = 8'h05;
    localparam logic [7:0] EV_HIGH2 = 8'h06;
    // Diagnostic error codes
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_WIRE_BREAK = 16'h0006;
    localparam logic [15:0] ERR_OVERFLOW = 16'h0007;
    localparam logic [15:0] ERR_UNDERFLOW = 16'h0008;
    localparam logic [15:0] ERR_PARAM = 16'h0010;
    localparam logic [15:0] ERR_COMMON_MODE = 16'h0118;
    // Fault bit positions within a channel fault vector, in check order
    localparam int FLT_WIRE_BREAK = 0;
    localparam int FLT_OVERFLOW = 1;
    localparam int FLT_UNDERFLOW = 2;
    localparam int FLT_COMMON_MODE = 3;
    localparam int FLT_PARAM = 4;
    localparam int FLT_W = 5;
    // Limit bit positions within a channel limit vector
    localparam int LIM_LOW1 = 0;
    localparam int LIM_HIGH1 = 1;
    localparam int LIM_LOW2 = 2;
    localparam int LIM_HIGH2 = 3;
    localparam int LIM_W = 4;
    // Error indicator flash period
    localparam int FLASH_NS = 250_000_000;
    localparam int CLK_NS = 4;
    localparam int FLASH_CYCLES = FLASH_NS / CLK_NS;
    // Hardware interrupt presentation states
    typedef enum logic [1:0] {
        HW_IDLE = 2'b01,
        HW_BUSY = 2'b10
    } hw_state_e;
endpackage : event_reporter_pkg

// *** src/analog_channel_event_reporter.sv ***
// Event and diagnostic reporter for a multi-channel analog input block.
// Assumes synchronous limit/fault level inputs and an APB master.
// Overview of operation
// RULE_01: Channel faults raise diagnostic interrupt
// RULE_02: Limit crossings raise hardware interrupt
// RULE_03: Start information records triggering channel
// RULE_04: Simultaneous high limits: high 1 first
// RULE_05: Ordering ignores high limit 2 setting
// RULE_06: High 2 only after high 1 processed
// RULE_07: Low limits ordered likewise, low 1 first
// RULE_08: Info word: structure id, channel, event
// RULE_09: Channel byte holds channel number
// RULE_10: Event codes 03, 04, 05, 06
// RULE_11: Diagnostic alarm flashes error indicator
// RULE_12: Wire break reports code 6
// RULE_13: Overflow code 7, underflow code 8
// RULE_14: Parameter error reports code 10 hex
// RULE_15: Common mode reports code 118 hex
// RULE_16: Outside value status mode all faults checked
// RULE_17: Value status mode stops at first fault
// RULE_18: Host should enable all diagnostics
// RULE_19: Per-channel value status flag, 0 invalid
// RULE_20: Second-limit event held pending without loss
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module analog_channel_event_reporter #(
    parameter int CHANNELS = 16,
    parameter int FLASH_CYCLES = event_reporter_pkg::FLASH_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CHANNELS*event_reporter_pkg::LIM_W-1:0] limit_cross,
    input wire logic [CHANNELS*event_reporter_pkg::FLT_W-1:0] fault_level,
    output logic hw_irq,
    output logic diag_irq,
    output logic error_led,
    output logic [CHANNELS-1:0] value_status_flag
);
    localparam int CW = $clog2(CHANNELS);
    localparam int NE = CHANNELS * event_reporter_pkg::LIM_W;

    // Error code of the first fault found in a fault vector
    function automatic logic [15:0] first_error(input logic [4:0] f);
        if (f[event_reporter_pkg::FLT_WIRE_BREAK])
            return event_reporter_pkg::ERR_WIRE_BREAK;
        else if (f[event_reporter_pkg::FLT_OVERFLOW])
            return event_reporter_pkg::ERR_OVERFLOW;
        else if (f[event_reporter_pkg::FLT_UNDERFLOW])
            return event_reporter_pkg::ERR_UNDERFLOW;
        else if (f[event_reporter_pkg::FLT_COMMON_MODE])
            return event_reporter_pkg::ERR_COMMON_MODE;
        else if (f[event_reporter_pkg::FLT_PARAM])
            return event_reporter_pkg::ERR_PARAM;
        else
            return event_reporter_pkg::ERR_NONE;
    endfunction : first_error

    // Mask keeping only the lowest set bit of a fault vector
    function automatic logic [4:0] first_only(input logic [4:0] f);
        return f & (~f + 5'h01);
    endfunction : first_only

    // Event code of a limit index
    function automatic logic [7:0] event_code(input logic [1:0] k);
        case (k)
            2'd0: return event_reporter_pkg::EV_LOW1;
            2'd1: return event_reporter_pkg::EV_HIGH1;
            2'd2: return event_reporter_pkg::EV_LOW2;
            default: return event_reporter_pkg::EV_HIGH2;
        endcase
    endfunction : event_code

    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] diag_en_q, diag_en_d;
    logic [NE-1:0] pend_q, pend_d;
    logic [NE-1:0] lim_prev_q, lim_prev_d;
    logic [CHANNELS-1:0] diag_q, diag_d;
    logic [15:0] err_q [CHANNELS];
    logic [15:0] err_d [CHANNELS];
    logic [CHANNELS*event_reporter_pkg::FLT_W-1:0] flt_prev_q, flt_prev_d;
    logic [CHANNELS-1:0] vsf_q, vsf_d;
    logic [31:0] info_q, info_d;
    logic [31:0] prdata_q, prdata_d;
    event_reporter_pkg::hw_state_e hw_state_q, hw_state_d;
    logic [31:0] flash_cnt_q, flash_cnt_d;
    logic led_q, led_d;
    logic wr_en, rd_en, hw_ack, vs_mode;
    logic [7:0] diag_sel;

    // APB decode, zero wait states
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite; // Setup cycle of a read
    assign pready = 1'b1;
    assign vs_mode = ctrl_q[event_reporter_pkg::CTRL_VS_MODE_BIT];
    assign hw_ack = wr_en & (paddr == event_reporter_pkg::OFF_HW_ACK);
    assign diag_sel = pwdata[15:8];

    always_comb
    begin
        pslverr = 1'b0;
        if (psel & penable)
        begin
            case (paddr)
                event_reporter_pkg::OFF_CTRL,
                event_reporter_pkg::OFF_DIAG_EN,
                event_reporter_pkg::OFF_HW_STATUS,
                event_reporter_pkg::OFF_HW_ACK,
                event_reporter_pkg::OFF_DIAG_STATUS,
                event_reporter_pkg::OFF_DIAG_ACK,
                event_reporter_pkg::OFF_VALUE_STATUS,
                event_reporter_pkg::OFF_START_INFO: pslverr = 1'b0;
                default: pslverr = 1'b1;
            endcase
        end
    end

    // Configuration registers
    always_comb
    begin
        ctrl_d = ctrl_q;
        diag_en_d = diag_en_q;
        if (wr_en && paddr == event_reporter_pkg::OFF_CTRL)
            ctrl_d = pwdata;
        if (wr_en && paddr == event_reporter_pkg::OFF_DIAG_EN)
            diag_en_d = {27'h0, pwdata[4:0]};
    end

    // Hardware interrupt capture and ordering
    always_comb
    begin
        int sel;
        int ch;
        logic [1:0] k;
        sel = -1;
        ch = 0;
        k = 2'd0;
        lim_prev_d = limit_cross;
        pend_d = pend_q;
        hw_state_d = hw_state_q;
        info_d = info_q;
        case (hw_state_q)
            event_reporter_pkg::HW_IDLE:
            begin
                // Lowest channel, then limit 1 before limit 2 per direction
                for (int i = NE - 1; i >= 0; i--)
                    if (pend_q[i])
                    begin
                        ch = i / event_reporter_pkg::LIM_W;
                        k = 2'(i % event_reporter_pkg::LIM_W);
                        if (k >= 2'd2 && pend_q[i - 2])
                            sel = i - 2; // RULE_04 RULE_05 RULE_07
                        else
                            sel = i;
                    end
                if (sel >= 0)
                begin
                    ch = sel / event_reporter_pkg::LIM_W;
                    k = 2'(sel % event_reporter_pkg::LIM_W);
                    info_d = {event_reporter_pkg::USER_STRUCTURE_ID, // RULE_08
                        8'(ch), event_code(k)}; // RULE_03 RULE_09 RULE_10
                    pend_d[sel] = 1'b0;
                    hw_state_d = event_reporter_pkg::HW_BUSY;
                end
            end
            event_reporter_pkg::HW_BUSY:
                // Next event only after the current one is processed
                if (hw_ack)
                    hw_state_d = event_reporter_pkg::HW_IDLE; // RULE_06 RULE_07
            default: hw_state_d = event_reporter_pkg::HW_IDLE;
        endcase
        // Rising edges queue after the take, so an edge in the cycle its bit is taken is not lost; repeat edges on a pending bit merge
        pend_d = pend_d | (limit_cross & ~lim_prev_q); // RULE_02 RULE_20
    end
    assign hw_irq = hw_state_q == event_reporter_pkg::HW_BUSY; // RULE_02

    // Diagnostic evaluation per channel
    always_comb
    begin
        logic [4:0] f;
        logic [4:0] fe;
        f = 5'h00;
        fe = 5'h00;
        diag_d = diag_q;
        flt_prev_d = fault_level;
        vsf_d = vsf_q;
        for (int c = 0; c < CHANNELS; c++)
        begin
            err_d[c] = err_q[c];
            f = fault_level[c*event_reporter_pkg::FLT_W +: 5];
            if (vs_mode)
                fe = first_only(f) & diag_en_q[4:0]; // RULE_16 RULE_17
            else
                fe = f & diag_en_q[4:0];
            vsf_d[c] = ~vs_mode | (f == 5'h00); // RULE_19
            if ((fe & ~flt_prev_q[c*event_reporter_pkg::FLT_W +: 5]) != 5'h00)
            begin
                diag_d[c] = 1'b1; // RULE_01
                err_d[c] = first_error(fe); // RULE_12 RULE_13 RULE_14 RULE_15
            end
            else if (wr_en && paddr == event_reporter_pkg::OFF_DIAG_ACK &&
                     pwdata[c])
                diag_d[c] = 1'b0;
        end
    end
    assign diag_irq = |diag_q; // RULE_01
    assign value_status_flag = vsf_q;

    // Flashing error indicator while any alarm stands
    always_comb
    begin
        flash_cnt_d = flash_cnt_q + 32'h1;
        led_d = led_q;
        if (!diag_irq)
        begin
            flash_cnt_d = 32'h0;
            led_d = 1'b0;
        end
        else if (flash_cnt_q >= 32'(FLASH_CYCLES - 1))
        begin
            flash_cnt_d = 32'h0;
            led_d = ~led_q; // RULE_11
        end
    end
    assign error_led = led_q;

    // Read data captured in the setup cycle, held through the access
    always_comb
    begin
        prdata_d = prdata_q;
        if (rd_en)
        begin
            case (paddr)
                event_reporter_pkg::OFF_CTRL: prdata_d = ctrl_q;
                event_reporter_pkg::OFF_DIAG_EN: prdata_d = diag_en_q;
                event_reporter_pkg::OFF_HW_STATUS:
                    prdata_d = {31'h0, hw_irq};
                event_reporter_pkg::OFF_DIAG_STATUS:
                    prdata_d = 32'(diag_q);
                event_reporter_pkg::OFF_DIAG_ACK:
                    prdata_d = {16'h0, err_q[diag_sel[CW-1:0]]};
                event_reporter_pkg::OFF_VALUE_STATUS: prdata_d = 32'(vsf_q);
                event_reporter_pkg::OFF_START_INFO: prdata_d = info_q;
                default: prdata_d = 32'h0;
            endcase
        end
    end
    assign prdata = prdata_q;

    // State registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= event_reporter_pkg::CTRL_RESET;
            diag_en_q <= event_reporter_pkg::DIAG_EN_RESET;
            pend_q <= '0;
            lim_prev_q <= '0;
            diag_q <= '0;
            flt_prev_q <= '0;
            vsf_q <= '0;
            info_q <= 32'h0;
            prdata_q <= 32'h0;
            hw_state_q <= event_reporter_pkg::HW_IDLE;
            flash_cnt_q <= 32'h0;
            led_q <= 1'b0;
            for (int c = 0; c < CHANNELS; c++)
                err_q[c] <= 16'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            diag_en_q <= diag_en_d;
            pend_q <= pend_d;
            lim_prev_q <= lim_prev_d;
            diag_q <= diag_d;
            flt_prev_q <= flt_prev_d;
            vsf_q <= vsf_d;
            info_q <= info_d;
            prdata_q <= prdata_d;
            hw_state_q <= hw_state_d;
            flash_cnt_q <= flash_cnt_d;
            led_q <= led_d;
            for (int c = 0; c < CHANNELS; c++)
                err_q[c] <= err_d[c];
        end
    end
endmodule : analog_channel_event_reporter
`default_nettype wire

// *** test/analog_channel_event_reporter_tb.sv ***
// Testbench for the event reporter: limit events, alarms, status mode.
// Field inputs driven directly; bus through the controller model.
`timescale 1ns/100ps
`default_nettype none
module analog_channel_event_reporter_tb;
    localparam int CH = 16;
    // Rows: channel, limit bits raised, expected event code
    localparam logic [23:0] ROWS [4] = '{24'h00_01_03, 24'h0F_02_04,
        24'h07_04_05, 24'h0A_08_06};
    localparam logic [15:0] ERRS [5] = '{16'h0006, 16'h0007, 16'h0008,
        16'h0118, 16'h0010};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic hw_irq, diag_irq, error_led;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [CH*event_reporter_pkg::LIM_W-1:0] lim = '0;
    logic [CH*event_reporter_pkg::FLT_W-1:0] flt = '0;
    logic [CH-1:0] vsf;
    int error_cnt = 0;
    int checks = 0;
    analog_channel_event_reporter #(.CHANNELS(CH), .FLASH_CYCLES(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .limit_cross(lim),
        .fault_level(flt), .hw_irq(hw_irq), .diag_irq(diag_irq),
        .error_led(error_led), .value_status_flag(vsf));
    controller_model cpu (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    // Compare helpers and bus shorthands
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        cpu.xfer(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
    endtask : rd_chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cpu.xfer(1'b1, a, d, rd, err);
    endtask : wr
    task automatic set_lim(input logic [7:0] ch, input logic [3:0] bits);
        @(posedge pclk);
        lim[ch*4 +: 4] <= bits;
    endtask : set_lim
    // Wait for the interrupt, check the start word, acknowledge it
    task automatic serve(input logic [7:0] ch, input logic [7:0] code);
        for (int i = 0; i < 20 && hw_irq !== 1'b1; i++)
            @(posedge pclk);
        chk(hw_irq, 1'b1);
        rd_chk(event_reporter_pkg::OFF_START_INFO,
            {16'h0001, ch, code});
        rd_chk(event_reporter_pkg::OFF_HW_STATUS, 32'h1);
        wr(event_reporter_pkg::OFF_HW_ACK, 32'h0);
        repeat (2) @(posedge pclk);
    endtask : serve
    task automatic conclude();
        if (error_cnt == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    // Clock source
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        conclude();
    end
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(event_reporter_pkg::OFF_CTRL, 32'h0);
        rd_chk(event_reporter_pkg::OFF_DIAG_EN, 32'h0);
        chk(vsf, 16'hFFFF);
        rd_chk(8'h40, 32'h0);
        chk(err, 1'b1);
        cpu.enable_all();
        foreach (ROWS[i])
        begin
            set_lim(ROWS[i][23:16], ROWS[i][11:8]);
            serve(ROWS[i][23:16], ROWS[i][7:0]);
            chk(hw_irq, 1'b0);
            set_lim(ROWS[i][23:16], 4'h0);
        end
        set_lim(8'h03, 4'hA);
        serve(8'h03, 8'h04);
        serve(8'h03, 8'h06);
        set_lim(8'h03, 4'h5);
        serve(8'h03, 8'h03);
        serve(8'h03, 8'h05);
        chk(hw_irq, 1'b0);
        for (int f = 0; f < 5; f++)
        begin
            flt[10+f] <= 1'b1;
            for (int i = 0; i < 20 && diag_irq !== 1'b1; i++)
                @(posedge pclk);
            chk(diag_irq, 1'b1);
            for (int i = 0; i < 20 && error_led !== 1'b1; i++)
                @(posedge pclk);
            chk(error_led, 1'b1);
            cpu.xfer(1'b0, event_reporter_pkg::OFF_DIAG_ACK, 32'h200, rd, err);
            chk(rd[15:0], ERRS[f]);
            rd_chk(event_reporter_pkg::OFF_DIAG_STATUS, 32'h4);
            flt <= '0;
            wr(event_reporter_pkg::OFF_DIAG_ACK, 32'h4);
            repeat (2) @(posedge pclk);
            chk(diag_irq, 1'b0);
            chk(error_led, 1'b0);
        end
        wr(event_reporter_pkg::OFF_CTRL, 32'h1);
        wr(event_reporter_pkg::OFF_DIAG_EN, 32'h4);
        flt[4:0] <= 5'b00101;
        repeat (4) @(posedge pclk);
        chk(diag_irq, 1'b0);
        chk(vsf[1:0], 2'b10);
        rd_chk(event_reporter_pkg::OFF_VALUE_STATUS, 32'h0000_FFFE);
        // Mid-run reset clears configuration and pending state
        lim <= '0;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(hw_irq, 1'b0);
        chk(vsf, 16'h0000);
        presetn <= 1'b1;
        rd_chk(event_reporter_pkg::OFF_CTRL, 32'h0);
        rd_chk(event_reporter_pkg::OFF_DIAG_EN, 32'h0);
        chk(vsf, 16'hFFFF);
        chk(diag_irq, 1'b0);
        conclude();
    end
endmodule : analog_channel_event_reporter_tb
`default_nettype wire

// *** test/controller_model.sv ***
// Controller side model: APB master reaching the reporter's registers.
// Assumes a slave on the same pclk that may insert wait states.
`timescale 1ns/100ps
`default_nettype none
module controller_model (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // Idle bus at start
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // Setup, then access held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // Released data no longer valid
    endtask : xfer
    // Configuration turns on every diagnostic type
    task automatic enable_all();
        logic [31:0] q;
        logic err;
        xfer(1'b1, event_reporter_pkg::OFF_DIAG_EN, 32'h1F, q, err);
    endtask : enable_all
endmodule : controller_model
`default_nettype wire

// *** test/event_reporter_checker_assertions.sv ***
// Checker for the event reporter: bus answer, interrupt and alarm timing.
// Bound to the reporter's top module; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module event_reporter_checker #(
    parameter int CHANNELS = 16,
    parameter int FLASH_CYCLES = event_reporter_pkg::FLASH_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [CHANNELS*event_reporter_pkg::LIM_W-1:0] limit_cross,
    input wire logic [CHANNELS*event_reporter_pkg::FLT_W-1:0] fault_level,
    input wire logic hw_irq,
    input wire logic diag_irq,
    input wire logic error_led,
    input wire logic [CHANNELS-1:0] value_status_flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic vs_q;
    logic led_q;
    int cnt_q;
    // Access phase strobe, psel with penable
    assign acc = psel && penable;
    // Mode bit copy and flash interval count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vs_q <= 1'b0;
            led_q <= 1'b0;
            cnt_q <= 0;
        end
        else
        begin
            led_q <= error_led;
            cnt_q <= (!diag_irq || error_led != led_q) ? 0 : cnt_q + 1;
            if (acc && pwrite && paddr == event_reporter_pkg::OFF_CTRL)
                vs_q <= pwdata[event_reporter_pkg::CTRL_VS_MODE_BIT];
        end
    end
    a_ready_no_wait: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_slverr_unmapped: assert property (acc |->
        pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0))
        else $error("pslverr does not match address map");
    a_hw_raise: assert property
        ((limit_cross & ~$past(limit_cross)) != '0 && !hw_irq
        |-> ##[1:3] hw_irq) else $error("limit crossing not signalled");
    a_hw_ack_drop: assert property (acc && pwrite && hw_irq &&
        paddr == event_reporter_pkg::OFF_HW_ACK |=> !hw_irq)
        else $error("hw_irq kept after acknowledge");
    a_diag_cause: assert property ($rose(diag_irq) |->
        $past(fault_level) != '0 || $past(fault_level, 2) != '0)
        else $error("diag_irq without a fault");
    a_led_quiet: assert property (!diag_irq [*2] |-> !error_led)
        else $error("error_led lit without alarm");
    a_led_flash: assert property (cnt_q <= FLASH_CYCLES + 2)
        else $error("error_led not flashing");
    a_status_valid: assert property (!vs_q [*3] |->
        value_status_flag == '1) else $error("status flag low");
    a_status_fault: assert property ((vs_q &&
        fault_level[event_reporter_pkg::FLT_W-1:0] != '0) [*3]
        |-> !value_status_flag[0]) else $error("faulty value shown valid");
    c_hw_ack: cover property (acc && pwrite && hw_irq);
    c_diag: cover property ($rose(diag_irq));
    c_slverr: cover property (acc && pslverr);
endmodule : event_reporter_checker
bind analog_channel_event_reporter event_reporter_checker #(
    .CHANNELS(CHANNELS), .FLASH_CYCLES(FLASH_CYCLES)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .limit_cross(limit_cross),
    .fault_level(fault_level), .hw_irq(hw_irq), .diag_irq(diag_irq),
    .error_led(error_led), .value_status_flag(value_status_flag));
`default_nettype wire
